// File: rtl/page_sign_defs.svh
// constants for the page signature command handler
// Notes on behaviour
// - the page signature command is recognised by code byte A5h.
// - page protection settings never block or alter signing of pages 0 to 5.
// - engine failure to sign returns result code 22h.
// - anonymous mode replaces every unique identifier byte with FFh.
// - illegal anonymity code or page number: no signing, result 77h.
// - response follows a dummy byte: length, result, then signature data.
// - key comes from page 6 unless its key source flag selects the internal key.
// - sixty-four signature bytes follow the result, s first then r.
// - parameter bits 2:0 pick the data page; only 0 to 5 are legal.
// - disabled device returns 88h with length one; success returns AAh.
// - parameter bits 7:5: 000b uses identifier, 111b anonymous, others invalid.
// - engine gets challenge, identifier, maker code, page data and key.
// - device sends dummy, length 65, result, signature, inverted crc-16.
// - a failure (22h) or bad-parameter (77h) result still sends sixty-four zero signature bytes.
// - message is identifier, page, challenge, page number, maker code low first.
`ifndef PAGE_SIGN_DEFS_SVH
`define PAGE_SIGN_DEFS_SVH

`define CMD_START_BYTE 8'h66
`define REQ_LEN_BYTE 8'h22
`define CMD_PAGE_SIGN 8'ha5
`define CHAL_LAST_IDX 7'h1f
`define RES_FAIL 8'h22
`define RES_BAD_PARAM 8'h77
`define RES_DISABLED 8'h88
`define RES_OK 8'haa
`define RSP_LEN_FULL 8'h41
`define RSP_LEN_SHORT 8'h01
`define DUMMY_BYTE 8'hff
`define ANONYMITY_SELECT_USE_ID 3'h0
`define ANONYMITY_SELECT_HIDE_ID 3'h7
`define LAST_DATA_PAGE 3'h5
`define CRC_POLY 16'ha001
`define TX_IDX_LEN 7'h01
`define TX_IDX_RESULT 7'h02
`define TX_IDX_SIG_LAST 7'h42
`define TX_IDX_LAST_FULL 7'h44
`define TX_IDX_LAST_SHORT 7'h04

`endif

// File: rtl/page_sign_pkg.sv
// types for the page signature command handler
package page_sign_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_LEN,
		ST_CMD,
		ST_PARAM,
		ST_CHAL,
		ST_RELEASE,
		ST_EVAL,
		ST_WAIT,
		ST_SEND
	} sign_state_t;

	typedef logic [7:0] byte_t;
	typedef logic [599:0] message_t;
	typedef logic [255:0] key_t;
	typedef logic [511:0] signature_t;

endpackage

// File: rtl/page_signature_command_handler.sv
// page signature command: frame decode, engine hand-off and response stream
`include "page_sign_defs.svh"

module page_signature_command_handler (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire page_sign_pkg::byte_t rx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output page_sign_pkg::byte_t tx_data,
	input wire logic device_disabled,
	output logic [2:0] page_sel,
	input wire page_sign_pkg::key_t page_data,
	input wire page_sign_pkg::key_t key_page_data,
	input wire logic key_source_flag,
	input wire page_sign_pkg::key_t puf_key,
	input wire logic [63:0] unique_identifier,
	input wire logic [15:0] maker_code,
	output logic eng_start,
	output page_sign_pkg::message_t eng_message,
	output page_sign_pkg::key_t eng_key,
	input wire logic eng_done,
	input wire logic eng_fail,
	input wire page_sign_pkg::signature_t eng_signature,
	output logic busy
);
	import page_sign_pkg::*;

	// ************************************************************
	// state and helpers
	// ************************************************************
	typedef struct packed {
		sign_state_t st;
		logic [6:0] idx;
		byte_t param;
		logic [255:0] chal;
		byte_t result;
		signature_t sig;
		logic [15:0] crc;
		logic start;
		message_t msg;
		key_t key;
	} handler_state_t;

	handler_state_t state_reg;
	handler_state_t state_next;
	logic rx_fire;
	logic buf_in_ready;
	logic buf_in_valid;
	byte_t buf_in_data;
	logic short_rsp;
	logic [6:0] last_idx;
	logic [2:0] anonymity_select_field;
	logic [2:0] page_field;
	logic param_ok;
	logic anonymity_select_on;

	// one-wire style crc-16, reflected polynomial
	function automatic logic [15:0] crc_step(input logic [15:0] crc_in, input byte_t data);
		logic [15:0] c;
		c = crc_in ^ {8'h00, data};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction

	assign anonymity_select_field = state_reg.param[7:5];
	assign page_field = state_reg.param[2:0];
	// bits 4 and 3 carry no meaning here
	assign anonymity_select_on = (anonymity_select_field == `ANONYMITY_SELECT_HIDE_ID);
	assign param_ok = ((anonymity_select_field == `ANONYMITY_SELECT_USE_ID) || anonymity_select_on)
		&& (page_field <= `LAST_DATA_PAGE);

	assign rx_ready = (state_reg.st == ST_IDLE) || (state_reg.st == ST_LEN)
		|| (state_reg.st == ST_CMD) || (state_reg.st == ST_PARAM)
		|| (state_reg.st == ST_CHAL) || (state_reg.st == ST_RELEASE);
	assign rx_fire = rx_valid && rx_ready;
	assign short_rsp = (state_reg.result == `RES_DISABLED);
	assign last_idx = short_rsp ? `TX_IDX_LAST_SHORT : `TX_IDX_LAST_FULL;
	assign buf_in_valid = (state_reg.st == ST_SEND);

	// ************************************************************
	// response byte selection
	// ************************************************************
	always_comb begin
		if (state_reg.idx == 7'h00) begin
			buf_in_data = `DUMMY_BYTE;
		end else if (state_reg.idx == `TX_IDX_LEN) begin
			buf_in_data = short_rsp ? `RSP_LEN_SHORT : `RSP_LEN_FULL;
		end else if (state_reg.idx == `TX_IDX_RESULT) begin
			buf_in_data = state_reg.result;
		end else if (state_reg.idx == last_idx) begin
			buf_in_data = ~state_reg.crc[15:8];
		end else if (state_reg.idx == last_idx - 7'h01) begin
			buf_in_data = ~state_reg.crc[7:0];
		end else begin
			buf_in_data = state_reg.sig[511:504]; // s then r, msb first
		end
	end

	// ************************************************************
	// command sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		state_next.start = 1'b0;
		case (state_reg.st)
			ST_IDLE: begin
				if (rx_fire && (rx_data == `CMD_START_BYTE)) begin
					state_next.st = ST_LEN;
				end
			end
			ST_LEN: begin
				if (rx_fire) begin
					state_next.st = (rx_data == `REQ_LEN_BYTE) ? ST_CMD : ST_IDLE;
				end
			end
			ST_CMD: begin
				if (rx_fire) begin
					state_next.st = (rx_data == `CMD_PAGE_SIGN) ? ST_PARAM : ST_IDLE;
				end
			end
			ST_PARAM: begin
				if (rx_fire) begin
					state_next.param = rx_data;
					state_next.idx = 7'h00;
					state_next.st = ST_CHAL;
				end
			end
			ST_CHAL: begin
				if (rx_fire) begin
					state_next.chal[{state_reg.idx[4:0], 3'h0} +: 8] = rx_data;
					state_next.idx = state_reg.idx + 7'h01;
					if (state_reg.idx == `CHAL_LAST_IDX) begin
						state_next.st = ST_RELEASE;
					end
				end
			end
			ST_RELEASE: begin
				if (rx_fire) begin
					state_next.st = ST_EVAL;
				end
			end
			ST_EVAL: begin
				state_next.idx = 7'h00;
				state_next.crc = 16'h0000;
				state_next.sig = '0;
				if (device_disabled) begin
					state_next.result = `RES_DISABLED;
					state_next.st = ST_SEND;
				end else if (!param_ok) begin
					state_next.result = `RES_BAD_PARAM;
					state_next.st = ST_SEND;
				end else begin
					// protection bits of the data page are never consulted
					state_next.msg[63:0] = anonymity_select_on ? {8{8'hff}} : unique_identifier;
					state_next.msg[319:64] = page_data;
					state_next.msg[575:320] = state_reg.chal;
					state_next.msg[583:576] = {5'h00, page_field};
					state_next.msg[599:584] = maker_code; // low byte first
					state_next.key = key_source_flag ? puf_key : key_page_data;
					state_next.start = 1'b1;
					state_next.st = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (eng_done) begin
					state_next.result = eng_fail ? `RES_FAIL : `RES_OK;
					state_next.sig = eng_fail ? '0 : eng_signature;
					state_next.st = ST_SEND;
				end
			end
			ST_SEND: begin
				if (buf_in_ready) begin
					state_next.idx = state_reg.idx + 7'h01;
					if ((state_reg.idx >= `TX_IDX_LEN) && (state_reg.idx < last_idx - 7'h01)) begin
						state_next.crc = crc_step(state_reg.crc, buf_in_data);
					end
					if ((state_reg.idx > `TX_IDX_RESULT) && (state_reg.idx <= `TX_IDX_SIG_LAST)) begin
						state_next.sig = {state_reg.sig[503:0], 8'h00};
					end
					if (state_reg.idx == last_idx) begin
						state_next.st = ST_IDLE;
					end
				end
			end
			default: begin
				state_next.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign page_sel = page_field;
	assign eng_start = state_reg.start;
	assign eng_message = state_reg.msg;
	assign eng_key = state_reg.key;
	assign busy = (state_reg.st != ST_IDLE);

	two_entry_buffer u_tx_buffer (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(buf_in_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

endmodule

// File: rtl/two_entry_buffer.sv
// two-entry byte buffer with valid and ready on both sides
module two_entry_buffer (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire page_sign_pkg::byte_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output page_sign_pkg::byte_t out_data
);
	import page_sign_pkg::*;

	typedef struct packed {
		byte_t [1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] count;
	} buf_state_t;

	buf_state_t state_reg;
	buf_state_t state_next;
	logic push;
	logic pop;

	assign in_ready = (state_reg.count != 2'h2);
	assign out_valid = (state_reg.count != 2'h0);
	assign out_data = state_reg.mem[state_reg.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = in_data;
			state_next.wr_ptr = ~state_reg.wr_ptr;
		end
		if (pop) begin
			state_next.rd_ptr = ~state_reg.rd_ptr;
		end
		case ({push, pop})
			2'b10: state_next.count = state_reg.count + 2'h1;
			2'b01: state_next.count = state_reg.count - 2'h1;
			default: state_next.count = state_reg.count;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

endmodule

// File: verif/page_sign_host_model.sv
// host model: sends request frames, collects reply bytes
module page_sign_host_model (
	input wire logic core_clk,
	input wire logic rx_ready,
	output logic rx_valid,
	output page_sign_pkg::byte_t rx_data,
	input wire logic tx_valid,
	input wire page_sign_pkg::byte_t tx_data,
	output logic tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	import page_sign_pkg::*;
	byte_t rsp [0:68];
	int got = 0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// ****
	// request and reply
	// ****
	task automatic put(input byte_t b);
		logic ok;
		rx_valid = 1'b1;
		rx_data = b;
		do begin
			ok = rx_ready;
			@(negedge core_clk);
		end while (!ok);
	endtask
	task automatic frame(input byte_t cmd, input byte_t param);
		put(8'h66);
		put(8'h22);
		put(cmd);
		put(param);
		for (int i = 0; i < 32; i++) put(8'(8'h30 + i));
		put(8'h00);
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
	task automatic take(input int n, input bit stall);
		int guard;
		guard = 0;
		got = 0;
		while (got < n && guard < 3000) begin
			tx_ready = !(stall && guard[1]);
			if (tx_valid && tx_ready) begin
				rsp[got] = tx_data;
				got++;
			end
			@(negedge core_clk);
			guard++;
		end
		tx_ready = 1'b0;
	endtask
endmodule

// File: verif/page_sign_monitor.sv
// port assertions for the page signature command handler
module page_sign_monitor (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire page_sign_pkg::byte_t tx_data,
	input wire logic busy,
	input wire logic eng_start,
	input wire logic eng_done,
	input wire page_sign_pkg::message_t eng_message,
	input wire page_sign_pkg::key_t eng_key,
	input wire logic key_source_flag,
	input wire page_sign_pkg::key_t puf_key,
	input wire page_sign_pkg::key_t key_page_data,
	input wire page_sign_pkg::key_t page_data,
	input wire logic [63:0] unique_identifier,
	input wire logic [15:0] maker_code,
	input wire logic [2:0] page_sel
);
	timeunit 1ns;
	timeprecision 1ns;
	import page_sign_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// ****
	// engine hand-off and reply
	// ****
	sequence s_done;
		busy && eng_done && !eng_start;
	endsequence
	sequence s_dummy_out;
		tx_valid && tx_data == 8'hff;
	endsequence
	AST_KEY_SEL: assert property (eng_start |->
		eng_key == (key_source_flag ? puf_key : key_page_data)) else $error("wrong key");
	AST_PAGE_NUM: assert property (eng_start |->
		page_sel <= 3'h5 && eng_message[583:576] == {5'h00, page_sel}) else $error("bad page");
	AST_ID_FIELD: assert property (eng_start |->
		eng_message[63:0] == unique_identifier || &eng_message[63:0]) else $error("bad id");
	AST_MSG_TAIL: assert property (eng_start |->
		eng_message[599:584] == maker_code && eng_message[319:64] == page_data)
		else $error("bad message");
	AST_START_ONE: assert property (eng_start |=> !eng_start) else $error("long start");
	AST_RX_SHUT: assert property (eng_start |-> busy && !rx_ready) else $error("rx open");
	AST_DONE_TX: assert property (s_done |-> ##2 s_dummy_out) else $error("no dummy");
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data)) else $error("tx dropped");
endmodule

bind page_signature_command_handler page_sign_monitor u_mon (.core_clk, .rst, .rx_ready,
	.tx_valid, .tx_ready, .tx_data, .busy, .eng_start, .eng_done, .eng_message, .eng_key,
	.key_source_flag, .puf_key, .key_page_data, .page_data, .unique_identifier, .maker_code,
	.page_sel);

// File: verif/page_signature_command_handler_tb.sv
// self-checking bench for the page signature command handler
module page_signature_command_handler_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import page_sign_pkg::*;
	localparam signature_t SIG = {8{64'h0123456789abcdef}};
	localparam key_t KEYP = {8{32'h6b6b0606}};
	localparam key_t PUF = {8{32'hd1d1e2e2}};
	localparam logic [63:0] UID = 64'h1122334455667708;
	logic core_clk = 0, rst = 1, device_disabled = 0, key_source_flag = 0, eng_fail = 0;
	logic [2:0] eng_pipe = 3'h0;
	int fails = 0, check_count = 0, cycles = 0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, eng_start, busy;
	byte_t rx_data, tx_data;
	logic [2:0] page_sel;
	message_t eng_message;
	key_t eng_key, page_data;
	assign page_data = {32{5'h15, page_sel}};
	always @(negedge core_clk) eng_pipe <= {eng_pipe[1:0], eng_start};
	page_signature_command_handler u_page_signature_command_handler (.core_clk, .rst,
		.rx_valid, .rx_ready, .rx_data, .tx_valid, .tx_ready, .tx_data, .device_disabled,
		.page_sel, .page_data, .key_page_data(KEYP), .key_source_flag, .puf_key(PUF),
		.unique_identifier(UID), .maker_code(16'h4d21), .eng_start, .eng_message, .eng_key,
		.eng_done(eng_pipe[2]), .eng_fail, .eng_signature(SIG), .busy);
	page_sign_host_model host (.core_clk, .rx_ready, .rx_valid, .rx_data, .tx_valid,
		.tx_data, .tx_ready);
	initial forever #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end
	// ****
	// checking
	// ****
	task chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	function automatic logic [15:0] crc(input int n);
		logic [15:0] c;
		c = 16'h0000;
		for (int i = 1; i < n - 2; i++) begin
			c = c ^ {8'h00, host.rsp[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return ~c;
	endfunction
	task run(input byte_t param, input bit stall, input byte_t res, input int n);
		host.frame(8'ha5, param);
		host.take(n, stall);
		chk(64'(host.got), 64'(n), "count");
		chk(host.rsp[0], 8'hff, "dummy");
		chk(host.rsp[1], n == 5 ? 8'h01 : 8'h41, "length");
		chk(host.rsp[2], res, "result");
		for (int k = 0; k < 64 && n == 69; k++)
			chk(host.rsp[3 + k], res == 8'haa ? SIG[511 - 8 * k -: 8] : 8'h00, "sig");
		chk({host.rsp[n - 1], host.rsp[n - 2]}, crc(n), "crc");
	endtask
	// ****
	// scenarios
	// ****
	task t_sign_id;
		run(8'h03, 1'b1, 8'haa, 69);
		chk(eng_message[63:0], UID, "id");
		chk(eng_key[63:0], KEYP[63:0], "key");
		chk(64'(page_sel), 64'h3, "page select");
		chk(64'(eng_message[71:64]), 64'hab, "page data");
		chk(64'(eng_message[599:576]), 64'h4d2103, "page and maker");
		for (int i = 0; i < 32; i++) begin
			chk(eng_message[8 * (40 + i) +: 8], 8'(8'h30 + i), "chal");
		end
	endtask
	task t_sign_anonymity_select;
		key_source_flag = 1'b1;
		run(8'he5, 1'b0, 8'haa, 69);
		chk(eng_message[63:0], 64'hffffffffffffffff, "anonymity_select id");
		chk(eng_key[63:0], PUF[63:0], "puf key");
		key_source_flag = 1'b0;
	endtask
	task t_bad_param;
		byte_t p [0:7] = '{8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'h06, 8'h07};
		for (int i = 0; i < 8; i++) run(p[i], 1'b0, 8'h77, 69);
	endtask
	task t_engine_fail;
		eng_fail = 1'b1;
		run(8'h01, 1'b0, 8'h22, 69);
		eng_fail = 1'b0;
	endtask
	task t_disabled;
		device_disabled = 1'b1;
		run(8'h02, 1'b1, 8'h88, 5);
		device_disabled = 1'b0;
	endtask
	task t_bad_cmd;
		host.put(8'h5a);
		chk(64'(busy), 64'h0, "stray busy");
		host.put(8'h66);
		chk(64'(busy), 64'h1, "start busy");
		host.put(8'h21);
		chk(64'(busy), 64'h0, "bad length busy");
		host.frame(8'hc9, 8'h01);
		repeat (4) @(negedge core_clk);
		chk(64'(busy), 64'h0, "busy");
		chk(64'(tx_valid), 64'h0, "tx valid");
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		t_sign_id();
		t_sign_anonymity_select();
		t_bad_param();
		t_engine_fail();
		t_disabled();
		t_bad_cmd();
		print_verdict();
	end
endmodule
